// >>> rtl/esp_pkg.sv
// Constants, types and helper functions shared by the serial EEPROM command logic.
// Assumes nothing beyond a SystemVerilog compiler.
// What this block does
// - Protect pin low with protect-enable set refuses every status register write.
// - Protect pin falling while selected aborts a pending status write, not a running one.
// - Protect-enable clear makes the protect pin irrelevant.
// - 8K and 16K take a 16-bit address using 10 or 11 bits.
// - 4K takes A8 from opcode bit 3; 1K ignores A7.
// - Block-protect codes select none, a quarter, lower half, first or last page.
// - Block-protect bits change only through write-status and are non-volatile.
// - Protected addresses stay readable but refuse writes.
// - Hardware protection blocks status writes and protected blocks, not unprotected ones.
// - Hardware protection is off when pin high or enable clear.
// - Cleared write latch refuses every array and status write.
// - Latch clear at reset, set only by set-latch, cleared by clear-latch.
// - Busy bit reads 1 during internal write, 0 when ready, not writable.
// - While held, SO floats, SI is ignored, the sequence resumes intact.
// - Read is opcode then address, then the addressed byte on SO.
// - Sequential read increments the pointer per byte, wrapping to zero.
// - Raising chip select ends a read and stops SO.
// - Read-status shifts status out, or all ones while a write runs.
// - Opcodes 06 set latch, 04 clear, 05 read status, 01 write status, X3 read, X2 write.
// - SI sampled on rising SCK, SO changed on falling SCK, modes 0,0 and 1,1.
// - Chip select high floats SO and ends the sequence.
package esp_pkg;

    // =====================================================
    // Densities and addressing
    typedef enum logic [2:0] {DENS_1K, DENS_2K, DENS_4K, DENS_8K, DENS_16K} esp_density_t;

    localparam int MAX_ADDR_W = 11;
    localparam int OP_A8_BIT  = 3;

    // =====================================================
    // Instruction codes
    localparam logic [7:0] OP_SET_LATCH = 8'h06;
    localparam logic [7:0] OP_CLR_LATCH = 8'h04;
    localparam logic [7:0] OP_RD_STATUS = 8'h05;
    localparam logic [7:0] OP_WR_STATUS = 8'h01;
    localparam logic [7:0] OP_XBIT_MASK = 8'hf7;
    localparam logic [7:0] OP_READ      = 8'h03;
    localparam logic [7:0] OP_WRITE     = 8'h02;

    // =====================================================
    // Status register
    typedef struct packed {
        logic       hwProtectEnable;
        logic [1:0] fixedOnes;
        logic [2:0] blockProtect;
        logic       writeLatchFlag;
        logic       busy;
    } esp_status_t;

    localparam logic [1:0] STATUS_FIXED_ONES = 2'h3;
    localparam logic [7:0] SO_BUSY_BYTE      = 8'hff;

    // Block-protect codes
    localparam logic [2:0] BP_NONE       = 3'h0;
    localparam logic [2:0] BP_Q1         = 3'h1;
    localparam logic [2:0] BP_Q4         = 3'h4;
    localparam logic [2:0] BP_LOWER_HALF = 3'h5;
    localparam logic [2:0] BP_FIRST_PAGE = 3'h6;
    localparam logic [2:0] BP_LAST_PAGE  = 3'h7;

    // =====================================================
    // Timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int TWC_MS        = 5;
    localparam int TWC_CYCLES    = TWC_MS * 1000000 / CLK_PERIOD_NS;

    // =====================================================
    // Density helpers
    function automatic int addrBits(input esp_density_t d);
        unique case (d)
            DENS_1K:  return 7;
            DENS_2K:  return 8;
            DENS_4K:  return 9;
            DENS_8K:  return 10;
            DENS_16K: return 11;
            default:  return MAX_ADDR_W;
        endcase
    endfunction

    function automatic int pageBits(input esp_density_t d);
        return (d == DENS_8K || d == DENS_16K) ? 5 : 4;
    endfunction

    function automatic logic twoAddrBytes(input esp_density_t d);
        return (d == DENS_8K || d == DENS_16K);
    endfunction

endpackage

// >>> rtl/esp_protect_read.sv
// Command side of a serial EEPROM: latch, status, protection, hold and reads.
// Assumes the array answers memRdata combinationally from memAddr in the SCK
// domain, and that a neighbour job sequences array writes on clk.
`timescale 1ns/1ps
`default_nettype none

module esp_protect_read
    import esp_pkg::*;
#(
    parameter esp_density_t DENSITY      = DENS_16K,
    parameter int unsigned  WRITE_CYCLES = TWC_CYCLES,
    parameter logic         NV_HW_PROTECT_ENABLE_INIT = 1'b0,
    parameter logic [2:0]   NV_BP_INIT   = BP_NONE
)
(
    // System
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    // Serial link pins
    input  wire logic                  sck,
    input  wire logic                  csN,
    input  wire logic                  si,
    input  wire logic                  holdN,
    input  wire logic                  wpN,
    output logic                       soData,
    output logic                       soOe,
    // Array read port, SCK domain
    output logic [MAX_ADDR_W-1:0]      memAddr,
    input  wire logic [7:0]            memRdata,
    // Neighbour write job, clk domain
    input  wire logic [MAX_ADDR_W-1:0] nbrAddr,
    input  wire logic                  nbrWriteStart,
    output logic                       arrayWriteOk,
    output logic                       hwProtectActive,
    output esp_status_t                status
);

    localparam int AW = addrBits(DENSITY);
    localparam logic [MAX_ADDR_W-1:0] ADDR_MASK = MAX_ADDR_W'((1 << AW) - 1);
    localparam int CNT_W = $clog2(WRITE_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(WRITE_CYCLES - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;
    localparam int NSYNC = 4;

    typedef enum logic [2:0] {
        LNK_OPCODE, LNK_ADDR_HI, LNK_ADDR_LO, LNK_READ, LNK_STATUS, LNK_WSTAT, LNK_IGNORE
    } esp_link_state_t;

    // =====================================================
    // Link domain (SCK); all but the status copies are cleared whenever chip select is high
    esp_link_state_t       state_q;
    logic [2:0]            bitCnt_q;
    logic [6:0]            shift_q;
    logic [MAX_ADDR_W-1:0] addr_q;
    logic [7:0]            cmdCode_q;
    logic                  cmdValid_q;
    logic [7:0]            statData_q;
    logic                  statValid_q;
    logic                  a8_q;
    logic [7:0]            soShift_q;
    logic                  soBit_q;
    logic                  soActive_q;
    esp_status_t           stSync1_q;
    esp_status_t           stSync_q;
    logic                  linkRst;
    logic [7:0]            byteIn;
    logic                  byteDone;
    logic                  loadByte;
    logic [7:0]            srcByte;

    assign linkRst  = csN | ~rst_n;
    assign byteIn   = {shift_q, si};
    assign byteDone = (bitCnt_q == 3'h7);

    // Status word crosses into SCK; it changes at chip select rising and as busy rises or falls, and busy
    // bytes are replaced by all ones, so a torn word is never shifted out
    always_ff @(posedge sck or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stSync1_q <= '0;
            stSync_q  <= '0;
        end
        else
        begin
            stSync1_q <= status;
            stSync_q  <= stSync1_q;
        end
    end

    // Bit shifter, sampled on rising SCK while not held
    always_ff @(posedge sck or posedge linkRst)
    begin
        if (linkRst)
        begin
            bitCnt_q <= 3'h0;
            shift_q  <= 7'h00;
        end
        else if (holdN)
        begin
            bitCnt_q <= bitCnt_q + 3'h1;
            shift_q  <= byteIn[6:0];
        end
    end

    // Command sequencer
    always_ff @(posedge sck or posedge linkRst)
    begin
        if (linkRst)
        begin
            state_q     <= LNK_OPCODE;
            addr_q      <= '0;
            cmdCode_q   <= 8'h00;
            cmdValid_q  <= 1'b0;
            statData_q  <= 8'h00;
            statValid_q <= 1'b0;
            a8_q        <= 1'b0;
        end
        else if (holdN && byteDone)
        begin
            unique case (state_q)
                LNK_OPCODE:
                begin
                    cmdCode_q  <= byteIn;
                    cmdValid_q <= 1'b1;
                    a8_q       <= byteIn[OP_A8_BIT];
                    if ((byteIn & OP_XBIT_MASK) == OP_READ && !stSync_q.busy)
                        state_q <= twoAddrBytes(DENSITY) ? LNK_ADDR_HI : LNK_ADDR_LO;
                    else if (byteIn == OP_RD_STATUS)
                        state_q <= LNK_STATUS;
                    else if (byteIn == OP_WR_STATUS)
                        state_q <= LNK_WSTAT;
                    else
                        state_q <= LNK_IGNORE;
                end
                LNK_ADDR_HI:
                begin
                    addr_q[MAX_ADDR_W-1:8] <= byteIn[MAX_ADDR_W-9:0] & ADDR_MASK[MAX_ADDR_W-1:8];
                    state_q                <= LNK_ADDR_LO;
                end
                LNK_ADDR_LO:
                begin
                    if (DENSITY == DENS_4K)
                        addr_q <= {2'h0, a8_q, byteIn};
                    else if (twoAddrBytes(DENSITY))
                        addr_q[7:0] <= byteIn;
                    else
                        addr_q <= {3'h0, byteIn} & ADDR_MASK;
                    state_q <= LNK_READ;
                end
                LNK_READ:
                    addr_q <= (addr_q + 11'h001) & ADDR_MASK;
                LNK_WSTAT:
                begin
                    statData_q  <= byteIn;
                    statValid_q <= 1'b1;
                    state_q     <= LNK_IGNORE;
                end
                LNK_STATUS,
                LNK_IGNORE:
                    state_q <= state_q;
            endcase
        end
    end

    assign memAddr  = addr_q;
    assign loadByte = (state_q == LNK_READ || state_q == LNK_STATUS) && bitCnt_q == 3'h0;

    always_comb
    begin
        if (state_q == LNK_READ)
            srcByte = memRdata;
        else if (stSync_q.busy)
            srcByte = SO_BUSY_BYTE;
        else
            srcByte = stSync_q;
    end

    // Output shifter, updated on falling SCK
    always_ff @(negedge sck or posedge linkRst)
    begin
        if (linkRst)
        begin
            soShift_q  <= 8'h00;
            soBit_q    <= 1'b0;
            soActive_q <= 1'b0;
        end
        else if (holdN)
        begin
            if (loadByte)
            begin
                soBit_q    <= srcByte[7];
                soShift_q  <= {srcByte[6:0], 1'b0};
                soActive_q <= 1'b1;
            end
            else
            begin
                soBit_q   <= soShift_q[7];
                soShift_q <= {soShift_q[6:0], 1'b0};
            end
        end
    end

    assign soData = soBit_q;
    assign soOe   = soActive_q & holdN & ~linkRst;

    // =====================================================
    // Crossings into clk: pins and frame-scoped event levels
    logic [NSYNC-1:0] syncIn;
    logic [NSYNC-1:0] sync1_q;
    logic [NSYNC-1:0] sync2_q;
    logic [NSYNC-1:0] prev_q;
    logic             csHigh;
    logic             wpHigh;
    logic             csRise;
    logic             cmdRise;
    logic             statRise;

    assign syncIn = {statValid_q, cmdValid_q, wpN, csN};

    for (genvar i = 0; i < NSYNC; i++)
    begin : g_sync
        always_ff @(posedge clk or negedge rst_n)
        begin
            if (!rst_n)
            begin
                sync1_q[i] <= 1'b1;
                sync2_q[i] <= 1'b1;
                prev_q[i]  <= 1'b1;
            end
            else
            begin
                sync1_q[i] <= syncIn[i];
                sync2_q[i] <= sync1_q[i];
                prev_q[i]  <= sync2_q[i];
            end
        end
    end

    assign csHigh   = sync2_q[0];
    assign wpHigh   = sync2_q[1];
    assign csRise   = sync2_q[0] & ~prev_q[0];
    assign cmdRise  = sync2_q[2] & ~prev_q[2];
    assign statRise = sync2_q[3] & ~prev_q[3];

    // =====================================================
    // Status register and write cycle, clk domain
    logic             hw_protect_enable_q;
    logic [2:0]       bp_q;
    logic             wel_q;
    logic             busy_q;
    logic [CNT_W-1:0] busyCnt_q;
    logic [7:0]       pendOp_q;
    logic             pendOpValid_q;
    logic             pendStat_q;
    logic [7:0]       pendStatData_q;
    logic             hwProt;
    logic             statusCommit;
    logic             busyStart;
    logic             busyEnd;
    logic             nbrHit;
    esp_status_t      pendFields;

    assign hwProt     = hw_protect_enable_q & ~wpHigh;
    assign pendFields = pendStatData_q;

    // Sequence captured from the link, acted on at chip select rising
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pendOp_q       <= 8'h00;
            pendOpValid_q  <= 1'b0;
            pendStat_q     <= 1'b0;
            pendStatData_q <= 8'h00;
        end
        else if (csRise)
        begin
            pendOpValid_q <= 1'b0;
            pendStat_q    <= 1'b0;
        end
        else
        begin
            if (cmdRise)
            begin
                pendOp_q      <= cmdCode_q;
                pendOpValid_q <= 1'b1;
            end
            if (statRise)
            begin
                pendStatData_q <= statData_q;
                pendStat_q     <= 1'b1;
            end
            else if (pendStat_q && !csHigh && hwProt)
                pendStat_q <= 1'b0;
        end
    end

    assign statusCommit = csRise && pendOpValid_q && pendOp_q == OP_WR_STATUS && pendStat_q
                          && wel_q && !hwProt && !busy_q;
    assign busyStart    = !busy_q && (statusCommit || nbrWriteStart);
    assign busyEnd      = busy_q && busyCnt_q == CNT_LAST;

    // Non-volatile protect fields, loaded only by a status write
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hw_protect_enable_q <= NV_HW_PROTECT_ENABLE_INIT;
            bp_q   <= NV_BP_INIT;
        end
        else if (statusCommit)
        begin
            hw_protect_enable_q <= pendFields.hwProtectEnable;
            bp_q   <= pendFields.blockProtect;
        end
    end

    // Write latch; latch commands are ignored while an internal write runs
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            wel_q <= 1'b0;
        else if (csRise && pendOpValid_q && !busy_q && pendOp_q == OP_SET_LATCH)
            wel_q <= 1'b1;
        else if (csRise && pendOpValid_q && !busy_q && pendOp_q == OP_CLR_LATCH)
            wel_q <= 1'b0;
        else if (busyEnd)
            wel_q <= 1'b0;
    end

    // Internal write cycle timer; a started cycle ignores the protect pin
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            busy_q    <= 1'b0;
            busyCnt_q <= CNT_ZERO;
        end
        else if (busyStart)
        begin
            busy_q    <= 1'b1;
            busyCnt_q <= CNT_ZERO;
        end
        else if (busyEnd)
            busy_q <= 1'b0;
        else if (busy_q)
            busyCnt_q <= busyCnt_q + 1'b1;
    end

    esp_region_check #(
        .DENSITY      (DENSITY)
    ) u_region (
        .blockProtect (bp_q),
        .addr         (nbrAddr),
        .protectedHit (nbrHit)
    );

    assign arrayWriteOk    = wel_q & ~busy_q & ~nbrHit;
    assign hwProtectActive = hwProt;

    always_comb
    begin
        status.hwProtectEnable = hw_protect_enable_q;
        status.fixedOnes       = STATUS_FIXED_ONES;
        status.blockProtect    = bp_q;
        status.writeLatchFlag  = wel_q;
        status.busy            = busy_q;
    end

endmodule

`default_nettype wire

// >>> rtl/esp_region_check.sv
// Block-protect region decoder: flags an address that the protect code covers.
// Assumes the address is already masked or carries don't-care upper bits.
`timescale 1ns/1ps
`default_nettype none

module esp_region_check
    import esp_pkg::*;
#(
    parameter esp_density_t DENSITY = DENS_16K
)
(
    // Protect code and address
    input  wire logic [2:0]            blockProtect,
    input  wire logic [MAX_ADDR_W-1:0] addr,
    // Result
    output logic                       protectedHit
);

    localparam int AW = addrBits(DENSITY);
    localparam int PW = pageBits(DENSITY);

    logic [1:0]    quarter;
    logic [AW-1:0] addrIn;

    assign addrIn  = addr[AW-1:0];
    assign quarter = addrIn[AW-1 -: 2];

    always_comb
    begin
        unique case (blockProtect)
            BP_NONE:       protectedHit = 1'b0;
            BP_LOWER_HALF: protectedHit = ~addrIn[AW-1];
            BP_FIRST_PAGE: protectedHit = ~|addrIn[AW-1:PW];
            BP_LAST_PAGE:  protectedHit = &addrIn[AW-1:PW];
            default:       protectedHit = (quarter == 2'(blockProtect - BP_Q1));
        endcase
    end

endmodule

`default_nettype wire

// >>> verif/esp_pr_asserts.sv
// Port checker for the serial EEPROM command block.
// Assumes a bind onto esp_protect_read from the testbench top.
`timescale 1ns/1ps
`default_nettype none
module esp_pr_asserts
    import esp_pkg::*;
#(
    parameter int unsigned WRITE_CYCLES = 20
)
(
    // System
    input wire logic        clk,
    input wire logic        rst_n,
    // Pins
    input wire logic        csN,
    input wire logic        holdN,
    input wire logic        wpN,
    input wire logic        soOe,
    // Clk side results
    input wire logic        arrayWriteOk,
    input wire logic        hwProtectActive,
    input wire esp_status_t status
);
    // ==========
    // Busy length
    int unsigned busyCnt_q;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            busyCnt_q <= 0;
        else
            busyCnt_q <= status.busy ? busyCnt_q + 1 : 0;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ==========
    // Properties
    chk_cs_float:
        assert property (csN |-> !soOe) else $error("SO on while deselected");
    chk_hold_float:
        assert property (!holdN |-> !soOe) else $error("SO on while held");
    chk_hwp_enable:
        assert property (!status.hwProtectEnable |-> !hwProtectActive) else $error("hwp no enable");
    chk_hwp_low:
        assert property ((status.hwProtectEnable && !wpN) [*3] |-> hwProtectActive)
        else $error("hwp missing");
    chk_hwp_high:
        assert property (wpN [*3] |-> !hwProtectActive) else $error("hwp with pin high");
    chk_fixed_ones:
        assert property (status.fixedOnes == STATUS_FIXED_ONES) else $error("fixed bits");
    chk_wel_gate:
        assert property (!status.writeLatchFlag |-> !arrayWriteOk) else $error("write no latch");
    chk_busy_len:
        assert property ($fell(status.busy) |->
            busyCnt_q inside {[WRITE_CYCLES-1:WRITE_CYCLES+1]}) else $error("busy length");
    chk_wel_end:
        assert property ($fell(status.busy) |-> ##[0:1] !status.writeLatchFlag)
        else $error("latch kept");
    chk_bp_change:
        assert property ($changed({status.hwProtectEnable, status.blockProtect}) |->
            status.busy) else $error("protect bits changed");
endmodule
`default_nettype wire

// >>> verif/esp_spi_master.sv
// Behavioural SPI master for the serial EEPROM pins.
// Assumes one task runs at a time; SO has no pull.
`timescale 1ns/1ps
`default_nettype none
module esp_spi_master
(
    // Link pins
    output logic       sck,
    output logic       csN,
    output logic       si,
    output logic       holdN,
    input  wire logic  soData,
    input  wire logic  soOe,
    // Received byte
    output logic [7:0] rxByte,
    output logic       rxValid
);
    localparam realtime HALF = 62.5;
    logic cpol;
    wire  soLine;
    // Floating SO shows the inverse of its last level
    assign soLine = soOe ? soData : ~soData;
    initial
    begin
        sck     = 1'b0;
        csN     = 1'b1;
        si      = 1'b0;
        holdN   = 1'b1;
        rxByte  = 8'h00;
        rxValid = 1'b0;
        cpol    = 1'b0;
    end
    // ==========
    // Frame tasks
    task automatic start(input logic mode);
        cpol = mode;
        sck  = mode;
        #HALF;
        csN  = 1'b0;
        #HALF;
    endtask
    task automatic xfer(input logic [7:0] tx, input logic watch);
        for (int i = 7; i >= 0; i--)
        begin
            sck       = 1'b0;
            si        = tx[i];
            #HALF;
            sck       = 1'b1;
            rxByte[i] = soLine;
            #HALF;
        end
        rxValid = watch;
        #1;
        rxValid = 1'b0;
    endtask
    // Pause with SCK low, SI toggling meanwhile
    task automatic pause(input int n);
        sck = 1'b0;
        #HALF;
        holdN = 1'b0;
        repeat (n)
        begin
            #HALF;
            si = 1'($urandom);
        end
        holdN = 1'b1;
        #HALF;
    endtask
    task automatic stop();
        sck = cpol;
        #HALF;
        csN = 1'b1;
        #HALF;
    endtask
endmodule
`default_nettype wire

// >>> verif/tb.sv
// Self-checking bench for the serial EEPROM command block, 16K density.
// Assumes the array answers a fixed pattern of the read address.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import esp_pkg::*;
    localparam int unsigned WC = 600;
    localparam logic [10:0] EDGES [10] = '{11'h000, 11'h01f, 11'h020, 11'h1ff, 11'h200,
                                           11'h3ff, 11'h400, 11'h7df, 11'h7e0, 11'h7ff};
    logic        clk, rst_n, sck, csN, si, holdN, wpN, soData, soOe, rxValid;
    logic        nbrWriteStart, arrayWriteOk, hwProtectActive;
    logic [10:0] memAddr, nbrAddr;
    logic [7:0]  memRdata, rxByte;
    esp_status_t status;
    logic [7:0]  expQ[$];
    int          bad_count = 0;
    int          n_tests = 0;
    function automatic logic [7:0] memVal(input logic [10:0] a);
        return a[7:0] ^ {5'h0, a[10:8]} ^ 8'h5a;
    endfunction
    function automatic logic prot(input logic [2:0] bp, input logic [10:0] a);
        return bp == 3'h5 ? !a[10] : bp == 3'h6 ? a < 11'h020 : bp == 3'h7 ? a >= 11'h7e0 :
               bp != 3'h0 && a[10:9] == bp[1:0] - 2'h1;
    endfunction
    assign memRdata = memVal(memAddr);
    esp_protect_read #(.DENSITY(DENS_16K), .WRITE_CYCLES(WC)) esp_protect_read_inst (
        .clk(clk), .rst_n(rst_n), .sck(sck), .csN(csN), .si(si), .holdN(holdN), .wpN(wpN),
        .soData(soData), .soOe(soOe), .memAddr(memAddr), .memRdata(memRdata),
        .nbrAddr(nbrAddr), .nbrWriteStart(nbrWriteStart), .arrayWriteOk(arrayWriteOk),
        .hwProtectActive(hwProtectActive), .status(status));
    esp_spi_master mst_inst (.sck(sck), .csN(csN), .si(si), .holdN(holdN), .soData(soData),
        .soOe(soOe), .rxByte(rxByte), .rxValid(rxValid));
    // ==========
    // Helpers
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    always @(posedge rxValid) check("so byte", rxByte, expQ.pop_front());
    task automatic cmd(input logic [7:0] op);
        mst_inst.start(1'b0);
        mst_inst.xfer(op, 1'b0);
        mst_inst.stop();
        tick(8);
    endtask
    task automatic read_status_cmd(input logic [7:0] exp, input logic mode);
        expQ.push_back(exp);
        mst_inst.start(mode);
        mst_inst.xfer(OP_RD_STATUS, 1'b0);
        mst_inst.xfer(8'h00, 1'b1);
        mst_inst.stop();
    endtask
    // Status write, then a status read while the write should run
    task automatic write_status_cmd(input logic [7:0] d, input logic [7:0] during);
        cmd(OP_SET_LATCH);
        mst_inst.start(1'b0);
        mst_inst.xfer(OP_WR_STATUS, 1'b0);
        mst_inst.xfer(d, 1'b0);
        mst_inst.stop();
        read_status_cmd(during, 1'b0);
        tick(WC);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial
    begin
        #300us;
        bad_count++;
        end_of_test();
    end
    // ==========
    // Tests
    initial
    begin
        rst_n = 1'b0;
        wpN = 1'b0;
        nbrAddr = 11'h000;
        nbrWriteStart = 1'b0;
        void'($urandom(42240));
        tick(20);
        rst_n = 1'b1;
        tick(8);
        check("reset", status, 8'h60);
        cmd(OP_SET_LATCH);
        check("latch set", status, 8'h62);
        nbrWriteStart = 1'b1;
        tick(1);
        nbrWriteStart = 1'b0;
        tick(3);
        check("busy", status, 8'h63);
        tick(WC);
        check("write end", status, 8'h60);
        cmd(OP_SET_LATCH);
        cmd(OP_CLR_LATCH);
        check("latch clear", status, 8'h60);
        check("no latch", 8'(arrayWriteOk), 8'h00);
        $display("test latch done");
        for (int c = 0; c < 8; c++)
        begin
            write_status_cmd({3'h0, 3'(c), 2'h3}, 8'hff);
            check("status", status, {3'h3, 3'(c), 2'h0});
            read_status_cmd({3'h3, 3'(c), 2'h0}, c[0]);
            cmd(OP_SET_LATCH);
            for (int k = 0; k < 11; k++)
            begin
                nbrAddr = k < 10 ? EDGES[k] : 11'($urandom);
                wpN = 1'($urandom);
                tick(1);
                check("region", 8'(arrayWriteOk), 8'(!prot(3'(c), nbrAddr)));
                check("hw protect off", 8'(hwProtectActive), 8'h00);
            end
        end
        $display("test protect codes done");
        wpN = 1'b0;
        write_status_cmd(8'h9c, 8'hff);
        check("status", status, 8'hfc);
        check("hw protect", 8'(hwProtectActive), 8'h01);
        write_status_cmd(8'h00, 8'hfe);
        check("refused", status, 8'hfe);
        nbrAddr = 11'h7ff;
        tick(1);
        check("protected", 8'(arrayWriteOk), 8'h00);
        nbrAddr = 11'h000;
        tick(1);
        check("unprotected", 8'(arrayWriteOk), 8'h01);
        wpN = 1'b1;
        tick(4);
        mst_inst.start(1'b0);
        mst_inst.xfer(OP_WR_STATUS, 1'b0);
        mst_inst.xfer(8'h00, 1'b0);
        tick(1);
        wpN = 1'b0;
        tick(6);
        wpN = 1'b1;
        tick(4);
        mst_inst.stop();
        tick(8);
        check("aborted", status, 8'hfe);
        wpN = 1'b1;
        tick(4);
        fork
            write_status_cmd(8'h00, 8'hff);
            begin
                @(posedge status.busy);
                tick(1);
                wpN = 1'b0;
            end
        join
        check("started", status, 8'h60);
        $display("test hardware protect done");
        expQ = '{memVal(11'h7fe), memVal(11'h7ff), memVal(11'h000)};
        mst_inst.start(1'b1);
        mst_inst.xfer(OP_READ, 1'b0);
        mst_inst.xfer(8'hff, 1'b0);
        mst_inst.xfer(8'hfe, 1'b0);
        mst_inst.xfer(8'h00, 1'b1);
        mst_inst.pause(4);
        mst_inst.xfer(8'h00, 1'b1);
        mst_inst.xfer(8'h00, 1'b1);
        mst_inst.stop();
        check("so off", 8'(soOe), 8'h00);
        check("all bytes", 8'(expQ.size()), 8'h00);
        $display("test read done");
        mst_inst.start(1'b0);
        mst_inst.xfer(8'h07, 1'b0);
        mst_inst.xfer(8'h00, 1'b0);
        check("bad op", 8'(soOe), 8'h00);
        mst_inst.stop();
        $display("test bad opcode done");
        end_of_test();
    end
endmodule
bind esp_protect_read esp_pr_asserts #(.WRITE_CYCLES(WRITE_CYCLES)) esp_pr_asserts_inst (
    .clk(clk), .rst_n(rst_n), .csN(csN), .holdN(holdN), .wpN(wpN), .soOe(soOe),
    .arrayWriteOk(arrayWriteOk), .hwProtectActive(hwProtectActive), .status(status));
`default_nettype wire
